// [rtl/bssw_host.sv]
// host end: drives one line command and reads back its status
`timescale 1ns/1ns
`include "bssw_regs.svh"
module bssw_host
  import bssw_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR_P = `BSSW_ADDR_DEFAULT,
  parameter int QUARTER = `BSSW_SCL_QUARTER_CYC,
  parameter int IDLE_WAIT = `BSSW_IDLE_WAIT_CYC
)
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  bssw_if.host bus,
  input wire logic req_valid_in,
  input wire logic req_write_byte_in,
  input wire logic [7:0] req_data_in,
  input wire logic req_poll_in,
  output logic req_ready_out,
  output logic done_out,
  output logic refused_out,
  output logic [7:0] status_out
);
  bssw_host_state_t state, next_state;
  logic [15:0] qcnt, next_qcnt, wcnt, next_wcnt;
  logic [1:0] phase, next_phase;
  logic [3:0] bitn, next_bitn;
  logic [7:0] tx, next_tx, rx, next_rx, data, next_data, status, next_status;
  logic scl, next_scl, sda_oe, next_sda_oe;
  logic wbyte, next_wbyte, poll, next_poll, second, next_second;
  logic fin, next_fin, refused, next_refused, acked, next_acked, done, next_done;
  logic tick, is_wr;

  assign tick = (qcnt == QUARTER[15:0] - 16'h1);
  assign is_wr = (state == HOST_ADDR) || (state == HOST_CMD) || (state == HOST_PARAM) ||
                 (state == HOST_ADDRR);

  always_comb
  begin
    next_state = state;
    next_qcnt = qcnt;
    next_wcnt = wcnt;
    next_phase = phase;
    next_bitn = bitn;
    next_tx = tx;
    next_rx = rx;
    next_data = data;
    next_status = status;
    next_scl = 1'b1;
    next_sda_oe = 1'b0;
    next_wbyte = wbyte;
    next_poll = poll;
    next_second = second;
    next_fin = fin;
    next_refused = refused;
    next_acked = acked;
    next_done = 1'b0;
    case (state)
      HOST_IDLE:
      begin
        if (req_valid_in)
        begin
          next_wbyte = req_write_byte_in;
          next_data = req_data_in;
          next_poll = req_poll_in;
          next_second = 1'b0;
          next_fin = 1'b0;
          next_refused = 1'b0;
          next_qcnt = 16'h0;
          next_phase = 2'h0;
          next_state = HOST_START;
        end
      end
      HOST_WAIT:
      begin
        // idle gap long enough for the line operation
        next_wcnt = wcnt + 16'h1;
        if (wcnt == IDLE_WAIT[15:0] - 16'h1)
        begin
          next_wcnt = 16'h0;
          next_qcnt = 16'h0;
          next_phase = 2'h0;
          next_state = HOST_START;
        end
      end
      default:
      begin
        next_qcnt = tick ? 16'h0 : qcnt + 16'h1;
        // every step is four quarters: setup, rise, sample, fall
        if (state == HOST_STOP)
        begin
          next_scl = (phase != 2'h0);
          next_sda_oe = (phase <= 2'h1);
        end
        else
        begin
          next_scl = (phase == 2'h1) || (phase == 2'h2);
          if (state == HOST_START)
          begin
            next_sda_oe = (phase >= 2'h2);
          end
          else if (is_wr)
          begin
            next_sda_oe = (bitn < 4'h8) && !tx[7];
          end
          else
          begin
            // ack while polling and busy, nack the final byte
            next_sda_oe = (bitn == 4'h8) && poll && rx[`BSSW_ST_BUSY_BIT];
          end
        end
        if (tick && phase == 2'h2)
        begin
          if (state == HOST_READ && bitn < 4'h8)
          begin
            next_rx = {rx[6:0], bus.sda};
          end
          if (is_wr && bitn == 4'h8)
          begin
            next_acked = ~bus.sda;
          end
        end
        if (tick)
        begin
          next_phase = phase + 2'h1;
        end
        if (tick && phase == 2'h3)
        begin
          if (state != HOST_START && state != HOST_STOP && bitn < 4'h8)
          begin
            next_bitn = bitn + 4'h1;
            next_tx = {tx[6:0], 1'b0};
          end
          else
          begin
            next_bitn = 4'h0;
            case (state)
              HOST_START:
              begin
                next_state = second ? HOST_ADDRR : HOST_ADDR;
                next_tx = {DEV_ADDR_P, second};
              end
              HOST_ADDR:
              begin
                next_tx = wbyte ? `BSSW_CMD_WBYTE : `BSSW_CMD_SLOT;
                next_refused = ~acked;
                next_state = acked ? HOST_CMD : HOST_STOP;
              end
              HOST_CMD:
              begin
                // refused code: stop at once and report
                next_tx = data;
                next_refused = ~acked;
                next_state = acked ? HOST_PARAM : HOST_STOP;
              end
              HOST_PARAM:
              begin
                next_second = 1'b1;
                next_state = poll ? HOST_START : HOST_STOP;
              end
              HOST_ADDRR:
              begin
                next_rx = 8'h00;
                next_refused = ~acked;
                next_state = acked ? HOST_READ : HOST_STOP;
              end
              HOST_READ:
              begin
                next_status = rx;
                if (!(poll && rx[`BSSW_ST_BUSY_BIT]))
                begin
                  next_fin = 1'b1;
                  next_state = HOST_STOP;
                end
              end
              HOST_STOP:
              begin
                if (refused || fin)
                begin
                  next_done = 1'b1;
                  next_state = HOST_IDLE;
                end
                else
                begin
                  next_state = HOST_WAIT;
                end
              end
              default:
              begin
                next_state = HOST_IDLE;
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= HOST_IDLE;
      qcnt <= 16'h0;
      wcnt <= 16'h0;
      phase <= 2'h0;
      bitn <= 4'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      data <= 8'h00;
      status <= `BSSW_ST_RESET;
      scl <= 1'b1;
      sda_oe <= 1'b0;
      wbyte <= 1'b0;
      poll <= 1'b0;
      second <= 1'b0;
      fin <= 1'b0;
      refused <= 1'b0;
      acked <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      qcnt <= next_qcnt;
      wcnt <= next_wcnt;
      phase <= next_phase;
      bitn <= next_bitn;
      tx <= next_tx;
      rx <= next_rx;
      data <= next_data;
      status <= next_status;
      scl <= next_scl;
      sda_oe <= next_sda_oe;
      wbyte <= next_wbyte;
      poll <= next_poll;
      second <= next_second;
      fin <= next_fin;
      refused <= next_refused;
      acked <= next_acked;
      done <= next_done;
    end
  end

  // clock driven push-pull, data open drain
  assign bus.scl = scl;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = sda_oe;
  assign req_ready_out = (state == HOST_IDLE);
  assign done_out = done;
  assign refused_out = refused;
  assign status_out = status;
endmodule

// [rtl/bssw_regs.svh]
// constants shared by both ends of the bridge command link
`ifndef BSSW_REGS_SVH
`define BSSW_REGS_SVH
`define BSSW_CMD_SLOT 8'h87
`define BSSW_CMD_WBYTE 8'hA5
`define BSSW_ST_BUSY_BIT 0
`define BSSW_ST_SBR_BIT 5
`define BSSW_ST_RESET 8'h00
// arbitrary neutral bus address
`define BSSW_ADDR_DEFAULT 7'h2A
`define BSSW_CLK_NS 10
`define BSSW_SCL_QUARTER_NS 2500
`define BSSW_SCL_QUARTER_CYC ((`BSSW_SCL_QUARTER_NS + `BSSW_CLK_NS - 1) / `BSSW_CLK_NS)
`define BSSW_IDLE_WAIT_CYC 2000
`endif

// [rtl/bssw_pkg.sv]
// types shared by both ends of the bridge command link
package bssw_pkg;
  typedef enum logic [2:0] {
    DEV_IDLE,
    DEV_ADDR,
    DEV_ACK,
    DEV_CMD,
    DEV_PARAM,
    DEV_READ,
    DEV_RACK,
    DEV_IGNORE
  } bssw_dev_state_t;
  typedef enum logic [3:0] {
    HOST_IDLE,
    HOST_START,
    HOST_ADDR,
    HOST_CMD,
    HOST_PARAM,
    HOST_ADDRR,
    HOST_READ,
    HOST_STOP,
    HOST_WAIT
  } bssw_host_state_t;
endpackage

// [rtl/bssw_if.sv]
// two-wire link between host and bridge device
`timescale 1ns/1ns
interface bssw_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  // wired-and of the open-drain drivers, pulled high otherwise
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface

// [rtl/bssw_dev.sv]
// bridge device end: command decode, busy flag and status readback
`timescale 1ns/1ns
`include "bssw_regs.svh"
// What this block does
// - host sends address, slot code, parameter, stop
// - non-polling host waits idle before next access
// - host reads one status byte, nacks, stops
// - polling host reads status until busy clears
// - slot result valid once busy falls
// - refused host stops and reports done, no restart
// - write-byte returns no sampled line data
// - busy falling marks write-byte complete
// - clock is input only, never stretched
// - slot command code is 87h
// - write-byte command code is A5h
module bssw_dev
  import bssw_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR_P = `BSSW_ADDR_DEFAULT
)
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  bssw_if.dev bus,
  output logic line_start_out,
  output logic line_slot_out,
  output logic [7:0] line_data_out,
  input wire logic line_done_in,
  input wire logic line_bit_in,
  output logic busy_out
);
  bssw_dev_state_t state, next_state, ack_next, next_ack_next;
  logic scl_q, sda_q;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  logic sda_oe, next_sda_oe;
  logic armed, next_armed;
  logic op_slot, next_op_slot;
  logic busy, next_busy;
  logic sbr, next_sbr;
  logic mack, next_mack;
  logic line_start, next_line_start;
  logic [7:0] line_data, next_line_data;
  logic [7:0] status;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  function automatic logic is_line_cmd(input logic [7:0] code);
    is_line_cmd = (code == `BSSW_CMD_SLOT) || (code == `BSSW_CMD_WBYTE);
  endfunction

  // the clock is only sampled; no port can hold it low
  assign scl_rise = bus.scl & ~scl_q;
  assign scl_fall = ~bus.scl & scl_q;
  assign bus_start = bus.scl & scl_q & sda_q & ~bus.sda;
  assign bus_stop = bus.scl & scl_q & ~sda_q & bus.sda;

  always_comb
  begin
    status = `BSSW_ST_RESET;
    status[`BSSW_ST_BUSY_BIT] = busy;
    status[`BSSW_ST_SBR_BIT] = sbr;
  end

  always_comb
  begin
    next_state = state;
    next_ack_next = ack_next;
    next_cnt = cnt;
    next_sh = sh;
    next_sda_oe = sda_oe;
    next_armed = armed;
    next_op_slot = op_slot;
    next_busy = busy;
    next_sbr = sbr;
    next_mack = mack;
    next_line_start = 1'b0;
    next_line_data = line_data;
    // completion clears busy; write-byte leaves the result bit alone
    if (line_done_in && busy)
    begin
      next_busy = 1'b0;
      if (op_slot)
      begin
        next_sbr = line_bit_in;
      end
    end
    if (bus_start || bus_stop)
    begin
      // a closed or restarted transfer launches the armed operation
      if (armed)
      begin
        next_line_start = 1'b1;
        next_armed = 1'b0;
      end
      next_sda_oe = 1'b0;
      next_cnt = 4'h0;
      next_state = bus_start ? DEV_ADDR : DEV_IDLE;
    end
    else
    begin
      case (state)
        DEV_IDLE:
        begin
          next_cnt = 4'h0;
        end
        DEV_ADDR, DEV_CMD, DEV_PARAM:
        begin
          if (scl_rise)
          begin
            next_sh = {sh[6:0], bus.sda};
            next_cnt = cnt + 4'h1;
          end
          else if (scl_fall && cnt == 4'h8)
          begin
            next_cnt = 4'h0;
            next_state = DEV_IGNORE;
            if (state == DEV_ADDR)
            begin
              if (sh[7:1] == DEV_ADDR_P)
              begin
                next_sda_oe = 1'b1;
                next_state = DEV_ACK;
                next_ack_next = sh[0] ? DEV_READ : DEV_CMD;
              end
            end
            else if (state == DEV_CMD)
            begin
              // busy or unknown codes get no acknowledge
              if (is_line_cmd(sh) && !busy)
              begin
                next_sda_oe = 1'b1;
                next_busy = 1'b1;
                next_op_slot = (sh == `BSSW_CMD_SLOT);
                next_state = DEV_ACK;
                next_ack_next = DEV_PARAM;
              end
            end
            else
            begin
              // parameter byte: slot selector or byte to send
              next_sda_oe = 1'b1;
              next_line_data = sh;
              next_armed = 1'b1;
              next_state = DEV_ACK;
              next_ack_next = DEV_IGNORE;
            end
          end
        end
        DEV_ACK:
        begin
          if (scl_fall)
          begin
            next_cnt = 4'h0;
            next_state = ack_next;
            next_sda_oe = 1'b0;
            if (ack_next == DEV_READ)
            begin
              // snapshot taken at byte start so the byte stays coherent
              next_sh = status;
              next_sda_oe = ~status[7];
            end
          end
        end
        DEV_READ:
        begin
          if (scl_rise)
          begin
            next_cnt = cnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (cnt == 4'h8)
            begin
              next_sda_oe = 1'b0;
              next_state = DEV_RACK;
            end
            else
            begin
              next_sh = {sh[6:0], 1'b0};
              next_sda_oe = ~sh[6];
            end
          end
        end
        DEV_RACK:
        begin
          if (scl_rise)
          begin
            next_mack = ~bus.sda;
          end
          else if (scl_fall)
          begin
            next_cnt = 4'h0;
            if (mack)
            begin
              next_state = DEV_READ;
              next_sh = status;
              next_sda_oe = ~status[7];
            end
            else
            begin
              next_state = DEV_IGNORE;
            end
          end
        end
        DEV_IGNORE:
        begin
          next_sda_oe = 1'b0;
        end
        default:
        begin
          next_state = DEV_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= DEV_IDLE;
      ack_next <= DEV_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt <= 4'h0;
      sh <= 8'h00;
      sda_oe <= 1'b0;
      armed <= 1'b0;
      op_slot <= 1'b0;
      busy <= 1'b0;
      sbr <= 1'b0;
      mack <= 1'b0;
      line_start <= 1'b0;
      line_data <= 8'h00;
    end
    else
    begin
      state <= next_state;
      ack_next <= next_ack_next;
      scl_q <= bus.scl;
      sda_q <= bus.sda;
      cnt <= next_cnt;
      sh <= next_sh;
      sda_oe <= next_sda_oe;
      armed <= next_armed;
      op_slot <= next_op_slot;
      busy <= next_busy;
      sbr <= next_sbr;
      mack <= next_mack;
      line_start <= next_line_start;
      line_data <= next_line_data;
    end
  end

  // open drain: only ever pulls low
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = sda_oe;
  assign line_start_out = line_start;
  assign line_slot_out = op_slot;
  assign line_data_out = line_data;
  assign busy_out = busy;
endmodule

// [verif/bssw_sva.sv]
// checker for the host to bridge link and the line side of the device
`timescale 1ns/1ns
module bssw_sva
#(
  parameter int QUARTER = 4
)
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic scl,
  input wire logic dev_sda_oe,
  input wire logic busy_out,
  input wire logic line_start_out,
  input wire logic line_slot_out,
  input wire logic line_done_in
);
  logic [15:0] scl_low_cnt;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // counts how long the clock sits low; a stretch would show up here
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      scl_low_cnt <= 16'h0000;
    end
    else if (scl)
    begin
      scl_low_cnt <= 16'h0000;
    end
    else
    begin
      scl_low_cnt <= scl_low_cnt + 16'h0001;
    end
  end
  a_scl_low_bound: assert property (scl_low_cnt <= 4 * QUARTER)
    else $error("bus clock held low too long");
  a_busy_falls_done: assert property (busy_out && line_done_in |=> !busy_out)
    else $error("busy did not clear after line done");
  a_busy_holds_set: assert property (busy_out && !line_done_in |=> busy_out)
    else $error("busy cleared without line done");
  a_start_needs_busy: assert property (line_start_out |-> busy_out)
    else $error("line op started while not busy");
  a_busy_with_ack: assert property ($rose(busy_out) |-> dev_sda_oe && !scl)
    else $error("busy rose without a command ack");
  a_start_single_pulse: assert property (line_start_out |=> !line_start_out [*8])
    else $error("line start repeated");
  a_drive_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data changed while clock high");
  a_slot_kept_busy: assert property (busy_out && $past(busy_out) |-> $stable(line_slot_out))
    else $error("op kind changed during a line op");
  c_line_start: cover property (line_start_out);
  c_busy_fall: cover property ($fell(busy_out));
  c_slot_op: cover property (line_start_out && line_slot_out);
endmodule

// [verif/testbench.sv]
// self-checking bench for both ends of the bridge command link
`timescale 1ns/1ns
module testbench;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid_in = 1'b0;
  logic req_write_byte_in = 1'b0;
  logic [7:0] req_data_in = 8'h00;
  logic req_poll_in = 1'b0;
  logic req_ready_out, done_out, refused_out, busy_out, line_start_out, line_slot_out;
  logic [7:0] status_out, line_data_out;
  logic line_done_in = 1'b0;
  logic line_bit_in = 1'b0;
  logic line_hold = 1'b0;
  int line_delay = 10;
  int line_cnt = 0;
  int starts = 0;
  int cycles = 0;
  int miscompares = 0;
  int tests_run = 0;
  bssw_if link();
  bssw_host #(.QUARTER(4), .IDLE_WAIT(40)) i_bssw_host (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus(link),
    .req_valid_in(req_valid_in), .req_write_byte_in(req_write_byte_in),
    .req_data_in(req_data_in), .req_poll_in(req_poll_in),
    .req_ready_out(req_ready_out), .done_out(done_out),
    .refused_out(refused_out), .status_out(status_out));
  bssw_dev i_bssw_dev (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus(link),
    .line_start_out(line_start_out), .line_slot_out(line_slot_out),
    .line_data_out(line_data_out), .line_done_in(line_done_in),
    .line_bit_in(line_bit_in), .busy_out(busy_out));
  bssw_sva #(.QUARTER(4)) i_bssw_sva (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl(link.scl),
    .dev_sda_oe(link.dev_sda_oe), .busy_out(busy_out),
    .line_start_out(line_start_out), .line_slot_out(line_slot_out),
    .line_done_in(line_done_in));
  always #5 sys_clk_in = ~sys_clk_in;
  // line side stand-in: finishes each op after line_delay cycles unless held
  always @(posedge sys_clk_in)
  begin
    line_done_in <= 1'b0;
    if (line_start_out === 1'b1)
    begin
      line_cnt <= line_delay;
      starts <= starts + 1;
    end
    else if (line_cnt > 1)
      line_cnt <= line_cnt - 1;
    else if (line_cnt == 1 && !line_hold)
    begin
      line_cnt <= 0;
      line_done_in <= 1'b1;
    end
  end
  always @(posedge sys_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      miscompares++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one host sequence; the bit result is set up front so it is stable at done
  task automatic run_req(input logic wb, input logic [7:0] d, input logic p, input logic b);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    check("ready idle", {7'h00, req_ready_out}, 8'h01);
    req_valid_in <= 1'b1;
    req_write_byte_in <= wb;
    req_data_in <= d;
    req_poll_in <= p;
    line_bit_in <= b;
    @(posedge sys_clk_in);
    req_valid_in <= 1'b0;
    @(negedge sys_clk_in);
    check("ready busy", {7'h00, req_ready_out}, 8'h00);
    while (done_out !== 1'b1 && n < 8000)
    begin
      @(negedge sys_clk_in);
      n++;
    end
    check("done seen", {7'h00, done_out}, 8'h01);
  endtask
  task automatic t_slot_nopoll();
    int s;
    line_delay = 10;
    s = starts;
    run_req(1'b0, 8'h80, 1'b0, 1'b1);
    check("slot one start", 8'(starts - s), 8'h01);
    check("slot kind", {7'h00, line_slot_out}, 8'h01);
    check("slot param", line_data_out, 8'h80);
    check("slot status", status_out, 8'h20);
    check("slot refused", {7'h00, refused_out}, 8'h00);
    $display("test slot without polling finished");
  endtask
  task automatic t_slot_poll();
    // longer than a whole status byte, so two busy reads get acked
    line_delay = 400;
    run_req(1'b0, 8'h00, 1'b1, 1'b0);
    check("poll status", status_out, 8'h00);
    check("poll busy", {7'h00, busy_out}, 8'h00);
    $display("test slot with polling finished");
  endtask
  task automatic t_wbyte_poll();
    line_delay = 300;
    run_req(1'b1, 8'h33, 1'b1, 1'b1);
    check("wbyte kind", {7'h00, line_slot_out}, 8'h00);
    check("wbyte data", line_data_out, 8'h33);
    check("wbyte status", status_out, 8'h00);
    $display("test write byte with polling finished");
  endtask
  // line op left hanging so both command codes meet a busy device
  task automatic t_refuse_busy();
    int s;
    line_delay = 5;
    line_hold = 1'b1;
    run_req(1'b0, 8'h80, 1'b0, 1'b0);
    check("busy status", status_out, 8'h01);
    s = starts;
    run_req(1'b0, 8'h80, 1'b1, 1'b0);
    check("slot refused", {7'h00, refused_out}, 8'h01);
    run_req(1'b1, 8'h55, 1'b1, 1'b0);
    check("wbyte refused", {7'h00, refused_out}, 8'h01);
    check("no new start", 8'(starts - s), 8'h00);
    check("kind kept", {7'h00, line_slot_out}, 8'h01);
    @(posedge sys_clk_in);
    line_hold <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    check("busy cleared", {7'h00, busy_out}, 8'h00);
    line_delay = 20;
    run_req(1'b1, 8'hA5, 1'b1, 1'b0);
    check("retry accepted", {7'h00, refused_out}, 8'h00);
    check("retry data", line_data_out, 8'hA5);
    $display("test refusal while busy finished");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_slot_nopoll();
    t_slot_poll();
    t_wbyte_poll();
    t_refuse_busy();
    stop_test();
  end
endmodule
